// File: ixap_defines.svh
// constants for the indexed axis-parameter and user-variable command decoder
`ifndef IXAP_DEFINES_SVH
`define IXAP_DEFINES_SVH
`define IXAP_FRAME_BYTES 4'h9
`define IXAP_MODULE_ADDR 8'h01
`define IXAP_HOST_ADDR 8'h02
`define IXAP_OP_SET_IX_AP 8'h10
`define IXAP_OP_GET_IX_AP 8'h11
`define IXAP_OP_ACCU_IX_AP 8'h12
`define IXAP_OP_DIRECT_UV 8'h37
`define IXAP_OP_UV_ACCU 8'h38
`define IXAP_OP_ACCU_UV 8'h39
`define IXAP_ST_OK 8'h64
`define IXAP_ST_BAD_CKS 8'h01
`define IXAP_ST_BAD_CMD 8'h02
`define IXAP_PARAM_ACT_POS 8'h01
`define IXAP_UV_MAX 32'sh000000FF
`define IXAP_NUM_AXES 32'sh00000006
`define IXAP_ACCU_RST 32'h00000000
`define IXAP_X_RST 32'h00000000
`endif

// File: ixap_pkg.sv
// types for the indexed axis-parameter and user-variable command decoder
package ixap_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] instr;
        logic [7:0] typ;
        logic [7:0] bank;
        logic [31:0] value;
        logic [7:0] cks;
    } ixap_frame_t;
    typedef struct packed {
        logic valid;
        logic [7:0] axis;
        logic [7:0] num;
        logic [31:0] data;
    } ixap_ap_wr_t;
    typedef struct packed {
        logic req;
        logic [7:0] axis;
        logic [7:0] num;
    } ixap_ap_rd_t;
    typedef enum logic [3:0] {
        IXAP_S_RX = 4'h1,
        IXAP_S_EXEC = 4'h2,
        IXAP_S_RDWAIT = 4'h4,
        IXAP_S_TX = 4'h8
    } ixap_state_t;
endpackage

// File: ixap_cmd.sv
// command decoder for the X-register indexed axis-parameter and user-variable instructions
// Behaviour
// [R01] frame: address, instruction, type, bank, four value bytes MSB first, checksum
// [R02] checksum is the modulo-256 sum of the eight bytes before it
// [R03] 0x10 sets parameter numbered by type with value, axis from X register
// [R04] set writes the supplied value into the parameter the type byte names
// [R05] host may put anything in bank byte; axis always comes from X
// [R06] 0x11 reads parameter numbered by type on X axis into accumulator
// [R07] get reply has status 100 and the value that was read
// [R08] parameter 1 read returns actual position of the X-selected axis
// [R09] 0x12 copies accumulator into parameter on X axis; bank, value ignored
// [R10] 0x37 stores the direct value into user variable indexed by X
// [R11] 0x38 loads accumulator from user variable indexed by X
// [R12] 0x39 stores accumulator into user variable indexed by X
// [R13] user-variable commands do nothing when X is outside 0..255
// [R14] set, accu-to-param and user-variable replies are status 100
// [R15] these commands mainly suit prepared standalone programs, not direct host use
// [R16] user-variable opcodes are 0x37, 0x38 and 0x39, all distinct
`timescale 1ns/1ns
`include "ixap_defines.svh"
module ixap_cmd (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // command byte stream from host
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    // reply byte stream to host
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    // axis parameter table outside this block
    output ixap_pkg::ixap_ap_wr_t ap_wr,
    output ixap_pkg::ixap_ap_rd_t ap_rd,
    input wire logic ap_rd_valid,
    input wire logic [31:0] ap_rd_data,
    input wire logic [5:0][31:0] act_pos,
    // program-side access to accumulator and X register
    input wire logic x_set_valid,
    input wire logic [31:0] x_set_value,
    input wire logic accu_set_valid,
    input wire logic [31:0] accu_set_value,
    output logic [31:0] accu_o,
    output logic [31:0] x_reg_o
);
    import ixap_pkg::*;

    // ==========================================
    // decode helpers
    function automatic logic uv_idx_ok(input logic [31:0] x);
        uv_idx_ok = ($signed(x) >= 0) && ($signed(x) <= `IXAP_UV_MAX);
    endfunction

    function automatic logic [7:0] sum8(input logic [63:0] b);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 8; i++) begin
            s = s + b[i*8 +: 8];
        end
        sum8 = s;
    endfunction

    // ==========================================
    // state
    ixap_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [71:0] rxb_r, rxb_nxt;
    logic [71:0] txb_r, txb_nxt;
    logic [31:0] accu_r, accu_nxt;
    logic [31:0] x_r, x_nxt;
    ixap_ap_wr_t apw_r, apw_nxt;
    ixap_ap_rd_t apr_r, apr_nxt;
    logic [31:0] uv_mem [256];
    logic uv_we;
    logic [7:0] uv_widx;
    logic [31:0] uv_wdata;
    ixap_frame_t fr;
    logic [31:0] uv_rdata;
    logic [7:0] axis;
    logic [31:0] pos_sel;

    assign fr = rxb_r; // [R01]
    assign axis = x_r[7:0]; // [R05]
    assign uv_rdata = uv_mem[x_r[7:0]];
    assign pos_sel = ($signed(x_r) >= 0 && $signed(x_r) < `IXAP_NUM_AXES) ?
                     act_pos[x_r[2:0]] : 32'h00000000;

    // handshake outputs straight from state
    assign rx_ready = (state_r == IXAP_S_RX);
    assign tx_valid = (state_r == IXAP_S_TX);
    assign tx_data = txb_r[71:64];
    assign ap_wr = apw_r;
    assign ap_rd = apr_r;
    assign accu_o = accu_r;
    assign x_reg_o = x_r;

    // ==========================================
    // next-state logic
    always_comb begin
        logic [63:0] rep;
        logic [7:0] st;
        logic [31:0] rv;
        logic send;
        rep = 64'h0;
        st = `IXAP_ST_OK;
        rv = 32'h00000000;
        send = 1'b0;
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        rxb_nxt = rxb_r;
        txb_nxt = txb_r;
        accu_nxt = accu_r;
        x_nxt = x_r;
        apw_nxt = '0;
        apr_nxt = apr_r;
        uv_we = 1'b0;
        uv_widx = x_r[7:0];
        uv_wdata = 32'h00000000;
        if (x_set_valid) begin
            x_nxt = x_set_value;
        end
        if (accu_set_valid) begin
            accu_nxt = accu_set_value;
        end
        case (state_r)
            IXAP_S_RX: begin
                if (rx_valid) begin
                    rxb_nxt = {rxb_r[63:0], rx_data}; // [R01]
                    if (cnt_r == `IXAP_FRAME_BYTES - 4'h1) begin
                        cnt_nxt = 4'h0;
                        state_nxt = IXAP_S_EXEC;
                    end else begin
                        cnt_nxt = cnt_r + 4'h1;
                    end
                end
            end
            IXAP_S_EXEC: begin
                state_nxt = IXAP_S_RX;
                if (fr.addr == `IXAP_MODULE_ADDR) begin
                    send = 1'b1;
                    if (sum8(rxb_r[71:8]) != fr.cks) begin // [R02]
                        st = `IXAP_ST_BAD_CKS;
                    end else begin
                        case (fr.instr)
                            `IXAP_OP_SET_IX_AP: begin
                                apw_nxt = '{1'b1, axis, fr.typ, fr.value}; // [R03] [R04]
                            end
                            `IXAP_OP_GET_IX_AP: begin
                                if (fr.typ == `IXAP_PARAM_ACT_POS) begin
                                    rv = pos_sel; // [R08]
                                    accu_nxt = pos_sel; // [R06]
                                end else begin
                                    send = 1'b0;
                                    apr_nxt = '{1'b1, axis, fr.typ}; // [R06]
                                    state_nxt = IXAP_S_RDWAIT;
                                end
                            end
                            `IXAP_OP_ACCU_IX_AP: begin
                                apw_nxt = '{1'b1, axis, fr.typ, accu_r}; // [R09]
                            end
                            `IXAP_OP_DIRECT_UV: begin // [R16]
                                uv_we = uv_idx_ok(x_r); // [R10] [R13]
                                uv_wdata = fr.value;
                            end
                            `IXAP_OP_UV_ACCU: begin
                                if (uv_idx_ok(x_r)) begin // [R13]
                                    accu_nxt = uv_rdata; // [R11]
                                end
                            end
                            `IXAP_OP_ACCU_UV: begin
                                uv_we = uv_idx_ok(x_r); // [R12] [R13]
                                uv_wdata = accu_r;
                            end
                            default: begin
                                st = `IXAP_ST_BAD_CMD;
                            end
                        endcase
                    end
                end
            end
            IXAP_S_RDWAIT: begin
                // the request holds until the table answers
                if (ap_rd_valid) begin
                    apr_nxt = '0;
                    accu_nxt = ap_rd_data; // [R06]
                    rv = ap_rd_data; // [R07]
                    send = 1'b1;
                end
            end
            IXAP_S_TX: begin
                if (tx_ready) begin
                    txb_nxt = {txb_r[63:0], 8'h00};
                    if (cnt_r == `IXAP_FRAME_BYTES - 4'h1) begin
                        cnt_nxt = 4'h0;
                        state_nxt = IXAP_S_RX;
                    end else begin
                        cnt_nxt = cnt_r + 4'h1;
                    end
                end
            end
            default: begin
                state_nxt = IXAP_S_RX;
                cnt_nxt = 4'h0;
            end
        endcase
        if (send) begin
            rep = {`IXAP_HOST_ADDR, `IXAP_MODULE_ADDR, st, fr.instr, rv}; // [R14] [R07]
            txb_nxt = {rep, sum8(rep)}; // [R02]
            cnt_nxt = 4'h0;
            state_nxt = IXAP_S_TX;
        end
    end

    // ==========================================
    // registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= IXAP_S_RX;
            cnt_r <= 4'h0;
            rxb_r <= 72'h0;
            txb_r <= 72'h0;
            accu_r <= `IXAP_ACCU_RST;
            x_r <= `IXAP_X_RST;
            apw_r <= '0;
            apr_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            rxb_r <= rxb_nxt;
            txb_r <= txb_nxt;
            accu_r <= accu_nxt;
            x_r <= x_nxt;
            apw_r <= apw_nxt;
            apr_r <= apr_nxt;
        end
    end

    // data store carries no reset; contents are undefined until written
    always_ff @(posedge clk_sys) begin
        if (uv_we) begin
            uv_mem[uv_widx] <= uv_wdata;
        end
    end

    // ==========================================
    // checks
    logic exec_ok;
    assign exec_ok = (state_r == IXAP_S_EXEC) && (fr.addr == `IXAP_MODULE_ADDR) &&
                     (sum8(rxb_r[71:8]) == fr.cks);

    sequence s_exec(logic [7:0] op);
        exec_ok && fr.instr == op;
    endsequence

    sequence s_reply_ok;
        tx_valid && txb_r[55:48] == `IXAP_ST_OK;
    endsequence

    a_set_write: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R03]
        s_exec(`IXAP_OP_SET_IX_AP) |=> ap_wr.valid && ap_wr.num == $past(fr.typ)
        && ap_wr.data == $past(fr.value) && ap_wr.axis == $past(x_r[7:0]))
        else $error("set did not write parameter");
    a_accu_write: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R09]
        s_exec(`IXAP_OP_ACCU_IX_AP) |=> ap_wr.valid && ap_wr.data == $past(accu_r))
        else $error("accu-to-param wrote wrong data");
    a_pos_read: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R08]
        s_exec(`IXAP_OP_GET_IX_AP) and (fr.typ == `IXAP_PARAM_ACT_POS
        && !accu_set_valid) |=> (accu_r == $past(pos_sel)) and s_reply_ok)
        else $error("position read wrong");
    a_get_reply: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R07]
        state_r == IXAP_S_RDWAIT && ap_rd_valid |=> s_reply_ok
        and (txb_r[39:8] == $past(ap_rd_data)))
        else $error("get reply value wrong");
    a_uv_range: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R13]
        uv_we |-> uv_idx_ok(x_r))
        else $error("user variable written out of range");
    a_uv_roundtrip: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R10]
        s_exec(`IXAP_OP_DIRECT_UV) and (uv_idx_ok(x_r) && !x_set_valid)
        |=> uv_mem[x_r[7:0]] == $past(fr.value))
        else $error("direct value not stored");
    a_uv_load: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R11]
        s_exec(`IXAP_OP_UV_ACCU) and (uv_idx_ok(x_r) && !accu_set_valid)
        |=> accu_r == $past(uv_rdata))
        else $error("user variable not loaded");
    a_accu_store: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R12]
        s_exec(`IXAP_OP_ACCU_UV) and uv_idx_ok(x_r) |-> uv_we && uv_wdata == accu_r)
        else $error("accu not stored");
    a_ok_status: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R14]
        s_exec(`IXAP_OP_ACCU_UV) or s_exec(`IXAP_OP_SET_IX_AP) |=> s_reply_ok)
        else $error("reply status not ok");
    a_reply_len: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R01]
        $rose(tx_valid) ##0 tx_ready [*8] ##1 tx_ready |=> !tx_valid)
        else $error("reply not nine bytes");
    a_cks_reply: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R02]
        $rose(tx_valid) |-> txb_r[7:0] == sum8(txb_r[71:8]))
        else $error("reply checksum wrong");
    a_bad_cks: assert property (@(posedge clk_sys) disable iff (!arst_n) // [R02]
        state_r == IXAP_S_EXEC && fr.addr == `IXAP_MODULE_ADDR && sum8(rxb_r[71:8]) != fr.cks
        |=> tx_valid && txb_r[55:48] == `IXAP_ST_BAD_CKS)
        else $error("bad checksum not reported");
endmodule

// File: ixap_host_model.sv
// host model: sends one command frame, then collects the nine reply bytes
`timescale 1ns/1ns
module ixap_host_model
    import ixap_pkg::*;
(
    // clock and control from the bench
    input wire logic clk_sys,
    input wire logic start,
    input ixap_pkg::ixap_frame_t frm,
    input wire logic [7:0] cks_flip,
    input wire logic want,
    // byte links
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    // collected reply
    output logic [71:0] reply,
    output logic done
);
    logic [71:0] fb;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h5A;
        tx_ready = 1'b0;
        reply = '0;
        done = 1'b0;
    end
    // ==========
    // one frame and its reply
    always @(posedge clk_sys) begin
        if (start) begin
            done <= 1'b0;
            fb = frm;
            fb[7:0] = cks_flip;
            for (int i = 1; i < 9; i++) begin
                fb[7:0] += fb[8*i +: 8];
            end
            for (int i = 8; i >= 0; i--) begin
                rx_valid <= 1'b1;
                rx_data <= fb[8*i +: 8];
                @(posedge clk_sys);
                while (rx_ready !== 1'b1)
                    @(posedge clk_sys);
            end
            rx_valid <= 1'b0;
            // released line shows the inverse, not a stale byte
            rx_data <= ~fb[7:0];
            tx_ready <= want;
            for (int i = 0; i < 9 && want; i++) begin
                @(posedge clk_sys);
                while (tx_valid !== 1'b1)
                    @(posedge clk_sys);
                reply = {reply[63:0], tx_data};
            end
            tx_ready <= 1'b0;
            repeat (4) @(posedge clk_sys);
            done <= 1'b1;
        end
    end
endmodule

// File: ixap_tb.sv
// self-checking bench for the indexed command decoder
`timescale 1ns/1ns
module tb;
    import ixap_pkg::*;
    typedef struct {
        logic [7:0] ins;
        logic [7:0] typ;
        logic [7:0] bank;
        logic [31:0] val;
        logic [31:0] x;
        logic [31:0] acc;
        int lat;
    } ixap_row_t;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic start = 1'b0;
    ixap_frame_t frm = '0;
    logic [7:0] cks_flip = 8'h00;
    logic want = 1'b1;
    logic rx_valid, rx_ready, tx_valid, tx_ready, done, hit;
    logic [7:0] rx_data, tx_data;
    logic [71:0] reply;
    ixap_ap_wr_t ap_wr, wr_last;
    ixap_ap_rd_t ap_rd;
    logic ap_rd_valid = 1'b0;
    logic [31:0] ap_rd_data = 32'h0;
    logic [5:0][31:0] act_pos;
    logic x_set_valid = 1'b0;
    logic accu_set_valid = 1'b0;
    logic [31:0] x_set_value = 32'h0;
    logic [31:0] accu_set_value = 32'h0;
    logic [31:0] accu_o, x_reg_o;
    logic [31:0] uv [256];
    int err_count = 0;
    int checks_done = 0;
    int wr_cnt = 0;
    int rd_wait = 0;
    int lat = 0;
    ixap_row_t rows [14] = '{
        '{8'h10, 8'h04, 8'h5A, 32'h0000C800, 32'h2, 32'h11, 0},
        '{8'h11, 8'h01, 8'hC3, 32'h0, 32'h3, 32'h0, 0},
        '{8'h11, 8'h04, 8'h00, 32'h0, 32'h1, 32'h0, 0},
        '{8'h11, 8'h06, 8'h00, 32'h0, 32'h4, 32'h0, 7},
        '{8'h12, 8'h00, 8'h33, 32'h12345678, 32'h5, 32'h777, 0},
        '{8'h37, 8'h00, 8'h00, 32'h3, 32'h0, 32'h0, 0},
        '{8'h37, 8'h00, 8'h00, 32'hDEADBEEF, 32'hFF, 32'h0, 0},
        '{8'h39, 8'h00, 8'h00, 32'h0, 32'h7, 32'hCAFE0001, 0},
        '{8'h37, 8'h00, 8'h00, 32'h11111111, 32'h100, 32'h0, 0},
        '{8'h39, 8'h00, 8'h00, 32'h0, 32'hFFFFFFFF, 32'h22, 0},
        '{8'h38, 8'h00, 8'h00, 32'h0, 32'h0, 32'h9, 0},
        '{8'h38, 8'h00, 8'h00, 32'h0, 32'hFF, 32'h9, 0},
        '{8'h38, 8'h00, 8'h00, 32'h0, 32'h7, 32'h9, 0},
        '{8'h38, 8'h00, 8'h00, 32'h0, 32'h80000000, 32'h9, 0}};
    always #5 clk_sys = ~clk_sys;
    ixap_cmd i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .ap_wr(ap_wr), .ap_rd(ap_rd), .ap_rd_valid(ap_rd_valid), .ap_rd_data(ap_rd_data),
        .act_pos(act_pos), .x_set_valid(x_set_valid), .x_set_value(x_set_value),
        .accu_set_valid(accu_set_valid), .accu_set_value(accu_set_value), .accu_o(accu_o),
        .x_reg_o(x_reg_o));
    ixap_host_model i_host (.clk_sys(clk_sys), .start(start), .frm(frm), .cks_flip(cks_flip),
        .want(want), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .reply(reply), .done(done));
    function automatic logic [31:0] tbl(input logic [7:0] a, input logic [7:0] n);
        return {a, n, 16'h3C5A};
    endfunction
    // ==========
    // axis table stand-in, answers after lat idle cycles
    always @(posedge clk_sys) begin
        hit = ap_rd.req === 1'b1 && ap_rd_valid !== 1'b1 && rd_wait >= lat;
        ap_rd_valid <= hit;
        ap_rd_data <= hit ? tbl(ap_rd.axis, ap_rd.num) : ~ap_rd_data;
        rd_wait <= (ap_rd.req === 1'b1 && !hit) ? rd_wait + 1 : 0;
        if (ap_wr.valid === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            wr_last <= ap_wr;
        end
    end
    task automatic check(input logic [71:0] seen, input logic [71:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ==========
    // one command: prepare X and accu, send, then compare
    task automatic do_row(input ixap_row_t r, input logic [7:0] adr, input logic [7:0] flip);
        logic [31:0] exp_acc;
        logic [31:0] exp_val;
        logic [7:0] s;
        logic good;
        logic ok;
        logic [7:0] exp_st;
        int wr0;
        int n;
        ok = $signed(r.x) >= 0 && $signed(r.x) <= 255;
        good = flip == 8'h00 && adr == 8'h01;
        exp_acc = r.acc;
        exp_val = 32'h0;
        x_set_valid <= 1'b1;
        x_set_value <= r.x;
        accu_set_valid <= 1'b1;
        accu_set_value <= r.acc;
        @(posedge clk_sys);
        x_set_valid <= 1'b0;
        accu_set_valid <= 1'b0;
        lat <= r.lat;
        frm <= {adr, r.ins, r.typ, r.bank, r.val, 8'h00};
        cks_flip <= flip;
        want <= adr == 8'h01;
        start <= 1'b1;
        wr0 = wr_cnt;
        @(posedge clk_sys);
        start <= 1'b0;
        n = 0;
        @(posedge clk_sys);
        while (done !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        check(done, 1'b1);
        if (good) begin
            case (r.ins)
                8'h11: exp_val = r.typ != 8'h01 ? tbl(r.x[7:0], r.typ) :
                    (r.x < 6 ? act_pos[r.x[2:0]] : 32'h0);
                8'h37: if (ok) uv[r.x[7:0]] = r.val;
                8'h38: if (ok) exp_acc = uv[r.x[7:0]];
                8'h39: if (ok) uv[r.x[7:0]] = r.acc;
                default: ;
            endcase
            if (r.ins == 8'h11) exp_acc = exp_val;
        end
        check(x_reg_o, r.x);
        check(accu_o, exp_acc);
        check(72'(wr_cnt - wr0), 72'(good && (r.ins == 8'h10 || r.ins == 8'h12)));
        if (good && (r.ins == 8'h10 || r.ins == 8'h12)) check(wr_last, {1'b1, r.x[7:0], r.typ,
            r.ins == 8'h10 ? r.val : r.acc});
        s = 8'h00;
        for (int i = 1; i < 9; i++) s += reply[8*i +: 8];
        if (adr == 8'h01) begin
            exp_st = good ? 8'h02 : 8'h01;
            if (good && r.ins inside {8'h10, 8'h11, 8'h12, 8'h37, 8'h38, 8'h39}) begin
                exp_st = 8'h64;
            end
            check(reply[71:40], {16'h0201, exp_st, r.ins});
            if (good && r.ins == 8'h11) check(reply[39:8], exp_val);
            check(reply[7:0], s);
        end else begin
            check(tx_valid, 1'b0);
        end
    endtask
    initial begin
        for (int i = 0; i < 6; i++) act_pos[i] = 32'h5EED0000 | 32'(i);
        repeat (6) @(posedge clk_sys);
        check({rx_ready, tx_valid, ap_wr.valid, ap_rd.req, accu_o, x_reg_o}, 72'h8 << 64);
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        for (int i = 0; i < 14; i++) begin
            do_row(rows[i], 8'h01, 8'h00);
            $display("test %0d done", i);
        end
        // corrupted checksum and foreign address must leave the variables alone
        do_row('{8'h37, 8'h00, 8'h00, 32'h99, 32'h0, 32'h0, 0}, 8'h01, 8'h01);
        do_row('{8'h39, 8'h00, 8'h00, 32'h0, 32'h0, 32'h55, 0}, 8'h05, 8'h00);
        // an unknown opcode must be refused and leave accu and table alone
        do_row('{8'h2F, 8'h00, 8'h00, 32'h0, 32'h0, 32'h44, 0}, 8'h01, 8'h00);
        do_row(rows[10], 8'h01, 8'h00);
        $display("test faults done");
        end_of_test();
    end
    initial begin
        repeat (6000) @(posedge clk_sys);
        err_count++;
        end_of_test();
    end
endmodule
